// [hw/ivf_consts.vh]
// constants for the input under-voltage fault response controller
`ifndef IVF_CONSTS_VH
`define IVF_CONSTS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define IVF_REG_FAULT_ACTION   8'h5A
`define IVF_REG_FAULT_ACTION_RST 8'hC0

// ---------------------------------------------------------------
// field layout of the fault action register
// ---------------------------------------------------------------
`define IVF_RESP_MSB           7
`define IVF_RESP_LSB           6
`define IVF_RETRY_MSB          5
`define IVF_RETRY_LSB          3
`define IVF_DELAY_MSB          2
`define IVF_DELAY_LSB          0

// ---------------------------------------------------------------
// response types and special retry codes
// ---------------------------------------------------------------
`define IVF_RESP_IGNORE        2'h0
`define IVF_RESP_RUN_DELAY     2'h1
`define IVF_RESP_DISABLE_RETRY 2'h2
`define IVF_RESP_LATCH_OFF     2'h3
`define IVF_RETRY_NONE         3'h0
`define IVF_RETRY_FOREVER      3'h7

// ---------------------------------------------------------------
// timing: default length of one delay unit
// ---------------------------------------------------------------
`define IVF_UNIT_CYC_DEFAULT   16'h0001

`endif

// [hw/ivf_delay_timer.v]
// delay timer counting two to the power of a code, in units of a set cycle count
module ivf_delay_timer #(
    parameter UNIT_W = 16
) (
    input  wire              clk_i,
    input  wire              rst_i,
    input  wire              start_i,   // load and restart the timer
    input  wire              stop_i,    // abandon a running interval
    input  wire [2:0]        code_i,    // interval is 2**code units
    input  wire [UNIT_W-1:0] unit_cyc_i, // cycles per unit, 0 taken as 1
    output reg               done_o,    // one-cycle pulse at expiry
    output reg               busy_o
);

    reg [UNIT_W-1:0] pre_r;
    reg [7:0]        units_r;
    reg [7:0]        target_r;

    wire unit_tick = (pre_r + {{(UNIT_W-1){1'b0}}, 1'b1} >= unit_cyc_i);

    // -----------------------------------------------------------
    // prescaler and unit counter
    // -----------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i || stop_i) begin
            pre_r    <= {UNIT_W{1'b0}};
            units_r  <= 8'h00;
            target_r <= 8'h01;
            busy_o   <= 1'b0;
            done_o   <= 1'b0;
        end else if (start_i) begin
            pre_r    <= {UNIT_W{1'b0}};
            units_r  <= 8'h00;
            target_r <= 8'h01 << code_i;
            busy_o   <= 1'b1;
            done_o   <= 1'b0;
        end else if (busy_o) begin
            done_o <= 1'b0;
            if (unit_tick) begin
                pre_r <= {UNIT_W{1'b0}};
                if (units_r + 8'h01 == target_r) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    units_r <= units_r + 8'h01;
                end
            end else begin
                pre_r <= pre_r + {{(UNIT_W-1){1'b0}}, 1'b1};
            end
        end else begin
            done_o <= 1'b0;
        end
    end

endmodule

// [hw/ivf_fault_ctrl.v]
// input under-voltage fault response controller
`include "ivf_consts.vh"

module ivf_fault_ctrl #(
    parameter UNIT_W = 16
) (
    // clock and reset
    input  wire              CLK_I,
    input  wire              RST_I,
    // register access by command code
    input  wire              REG_WR_I,
    input  wire              REG_RD_I,
    input  wire [7:0]        REG_CMD_I,
    input  wire [7:0]        REG_WDATA_I,
    output reg  [7:0]        REG_RDATA_O,
    // time unit for this fault, cycles per unit
    input  wire [UNIT_W-1:0] UNIT_CYC_I,
    // fault and command inputs
    input  wire              UV_FAULT_I,
    input  wire              CTRL_PIN_I,
    input  wire              OPERATION_ON_I,
    input  wire              CLEAR_FAULTS_I,
    input  wire              STATUS_CLR_I,
    input  wire              OTHER_FAULT_I,
    // outputs
    output reg               OUTPUT_EN_O,
    output reg               UV_STATUS_O,
    output reg  [2:0]        STATE_O,
    output reg  [2:0]        ATTEMPTS_O
);

    // -----------------------------------------------------------
    // states
    // -----------------------------------------------------------
    localparam ST_OFF     = 3'h0;
    localparam ST_RUN     = 3'h1;
    localparam ST_DELAY   = 3'h2;
    localparam ST_WAIT    = 3'h3;
    localparam ST_ATTEMPT = 3'h4;
    localparam ST_LATCH   = 3'h5;

    reg  [7:0] action_r;
    reg        ctrl_s1_r;
    reg        ctrl_s2_r;
    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [2:0] attempts_r;
    reg  [2:0] attempts_nxt;
    reg        tmr_start;
    reg        clear_seen_r;

    wire [1:0] resp_f  = action_r[`IVF_RESP_MSB:`IVF_RESP_LSB];
    wire [2:0] retry_f = action_r[`IVF_RETRY_MSB:`IVF_RETRY_LSB];
    wire [2:0] delay_f = action_r[`IVF_DELAY_MSB:`IVF_DELAY_LSB];
    wire       on_cmd  = ctrl_s2_r & OPERATION_ON_I;
    wire       clr_req = CLEAR_FAULTS_I | STATUS_CLR_I;
    wire       tmr_done;
    wire       tmr_stop = ~on_cmd;

    // -----------------------------------------------------------
    // control pin synchroniser
    // -----------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl_s1_r <= 1'b0;
            ctrl_s2_r <= 1'b0;
        end else begin
            ctrl_s1_r <= CTRL_PIN_I;
            ctrl_s2_r <= ctrl_s1_r;
        end
    end

    // -----------------------------------------------------------
    // fault action register and read port
    // -----------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RST_I) begin
            action_r    <= `IVF_REG_FAULT_ACTION_RST;
            REG_RDATA_O <= 8'h00;
        end else begin
            if (REG_WR_I && REG_CMD_I == `IVF_REG_FAULT_ACTION)
                action_r <= REG_WDATA_I;
            if (REG_RD_I && REG_CMD_I == `IVF_REG_FAULT_ACTION)
                REG_RDATA_O <= action_r;
            else if (REG_RD_I)
                REG_RDATA_O <= 8'h00;   // other command codes are not ours
        end
    end

    // -----------------------------------------------------------
    // sticky status bit: a new fault wins over a clear
    // -----------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RST_I)
            UV_STATUS_O <= 1'b0;
        else if (UV_FAULT_I)
            UV_STATUS_O <= 1'b1;
        else if (clr_req || !on_cmd)
            UV_STATUS_O <= 1'b0;
    end

    // clear request delayed by one cycle, in every state, for the latch exit
    always @(posedge CLK_I) begin
        if (RST_I)
            clear_seen_r <= 1'b0;
        else
            clear_seen_r <= clr_req;
    end

    // -----------------------------------------------------------
    // delay and retry-interval timer, unit length from outside
    // -----------------------------------------------------------
    ivf_delay_timer #(
        .UNIT_W     (UNIT_W)
    ) u_timer (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .start_i    (tmr_start),
        .stop_i     (tmr_stop),
        .code_i     (delay_f),
        .unit_cyc_i (UNIT_CYC_I),
        .done_o     (tmr_done),
        .busy_o     ()              // sequencer tracks the interval by state
    );

    // -----------------------------------------------------------
    // next state of the response sequencer
    // -----------------------------------------------------------
    always @* begin
        state_nxt    = state_r;
        attempts_nxt = attempts_r;
        tmr_start    = 1'b0;
        if (!on_cmd) begin
            state_nxt    = ST_OFF;
            attempts_nxt = 3'h0;
        end else if (OTHER_FAULT_I && state_r != ST_OFF) begin
            state_nxt    = ST_LATCH;
            attempts_nxt = 3'h0;
        end else begin
            case (state_r)
                ST_OFF: begin
                    state_nxt    = ST_RUN;
                    attempts_nxt = 3'h0;
                end
                ST_RUN: begin
                    if (UV_FAULT_I) begin
                        case (resp_f)
                            `IVF_RESP_IGNORE: begin
                                state_nxt = ST_RUN;
                            end
                            `IVF_RESP_RUN_DELAY: begin
                                state_nxt = ST_DELAY;
                                tmr_start = 1'b1;
                            end
                            `IVF_RESP_DISABLE_RETRY: begin
                                attempts_nxt = 3'h0;
                                if (retry_f == `IVF_RETRY_NONE) begin
                                    state_nxt = ST_LATCH;
                                end else begin
                                    state_nxt = ST_WAIT;
                                    tmr_start = 1'b1;
                                end
                            end
                            default: begin
                                state_nxt = ST_LATCH;
                            end
                        endcase
                    end
                end
                ST_DELAY: begin
                    if (!UV_FAULT_I) begin
                        state_nxt = ST_RUN;
                    end else if (tmr_done) begin
                        attempts_nxt = 3'h0;
                        if (retry_f == `IVF_RETRY_NONE) begin
                            state_nxt = ST_LATCH;
                        end else begin
                            state_nxt = ST_WAIT;
                            tmr_start = 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (tmr_done) begin
                        state_nxt = ST_ATTEMPT;
                        tmr_start = 1'b1;
                        if (retry_f != `IVF_RETRY_FOREVER)
                            attempts_nxt = attempts_r + 3'h1;
                    end
                end
                ST_ATTEMPT: begin
                    if (UV_FAULT_I) begin
                        if (retry_f == `IVF_RETRY_FOREVER ||
                            attempts_r < retry_f) begin
                            state_nxt = ST_WAIT;
                            tmr_start = 1'b1;
                        end else begin
                            state_nxt = ST_LATCH;
                        end
                    end else if (tmr_done) begin
                        state_nxt    = ST_RUN;            // restart held clean
                        attempts_nxt = 3'h0;
                    end
                end
                ST_LATCH: begin
                    if (clear_seen_r && !UV_STATUS_O) begin
                        state_nxt    = ST_RUN;
                        attempts_nxt = 3'h0;
                    end
                end
                default: begin
                    state_nxt    = ST_OFF;
                    attempts_nxt = 3'h0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------
    // state, counter and output registers
    // -----------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RST_I) begin
            state_r     <= ST_OFF;
            attempts_r  <= 3'h0;
            OUTPUT_EN_O <= 1'b0;
            STATE_O     <= ST_OFF;
            ATTEMPTS_O  <= 3'h0;
        end else begin
            state_r     <= state_nxt;
            attempts_r  <= attempts_nxt;
            STATE_O     <= state_nxt;
            ATTEMPTS_O  <= attempts_nxt;
            // output runs in normal, delay and attempt states
            OUTPUT_EN_O <= (state_nxt == ST_RUN) ||
                           (state_nxt == ST_DELAY) ||
                           (state_nxt == ST_ATTEMPT);
        end
    end

endmodule

// [sim/ivf_host_model.sv]
// host model: register strobes and clear commands
module ivf_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic            wr,
    output logic            rd,
    output logic [7:0]      cmd,
    output logic [7:0]      wdata,
    output logic            clr,
    output logic            sclr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr, rd, clr, sclr, cmd, wdata} = 20'h00000;
    // one byte write, released lines show inverted data
    task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        #1;
        {wr, cmd, wdata} = {1'b1, c, d};
        @(posedge clk);
        #1;
        {wr, cmd, wdata} = {1'b0, ~c, ~d};
    endtask
    // one byte read, data taken after the taking edge
    task automatic rd_reg(input logic [7:0] c, output logic [7:0] d);
        @(posedge clk);
        #1;
        {rd, cmd} = {1'b1, c};
        @(posedge clk);
        #1;
        {rd, cmd} = {1'b0, ~c};
        d = rdata;
    endtask
    // clear-faults or status-bit clear pulse
    task automatic clear(input logic bit_only);
        @(posedge clk);
        #1;
        {clr, sclr} = {!bit_only, bit_only};
        @(posedge clk);
        #1;
        {clr, sclr} = 2'b00;
    endtask
endmodule

// [sim/ivf_fault_ctrl_assertions.sv]
// checker for the fault response controller
module ivf_chk (
    input wire logic       CLK_I,
    input wire logic       RST_I,
    input wire logic       REG_WR_I,
    input wire logic       REG_RD_I,
    input wire logic [7:0] REG_CMD_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic       UV_FAULT_I,
    input wire logic       OTHER_FAULT_I,
    input wire logic       OPERATION_ON_I,
    input wire logic       OUTPUT_EN_O,
    input wire logic [2:0] STATE_O,
    input wire logic [2:0] ATTEMPTS_O
);
    logic [7:0] act_r;
    // shadow of the fault action register
    always @(posedge CLK_I) begin
        if (RST_I) begin
            act_r <= 8'hC0;
        end else if (REG_WR_I && REG_CMD_I == 8'h5A) begin
            act_r <= REG_WDATA_I;
        end
    end
    wire [1:0] resp = act_r[7:6];
    wire [2:0] rtry = act_r[5:3];
    wire       hit  = STATE_O == 3'h1 && UV_FAULT_I && OPERATION_ON_I && !REG_WR_I &&
                      !OTHER_FAULT_I;
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    AST_IGNORE: assert property (hit && resp == 2'h0 |=> OUTPUT_EN_O && STATE_O == 3'h1)
        else $error("fault not ignored");
    AST_DELAY_ON: assert property (hit && resp == 2'h1 |=> OUTPUT_EN_O && STATE_O == 3'h2)
        else $error("output not kept on in delay");
    AST_DISABLE: assert property (hit && resp == 2'h2 |=> !OUTPUT_EN_O)
        else $error("output not disabled at once");
    AST_LATCH: assert property (hit && resp == 2'h3 |=> STATE_O == 3'h5 && !OUTPUT_EN_O)
        else $error("no latch off");
    AST_NO_RETRY: assert property (hit && resp == 2'h2 && rtry == 3'h0 |=> STATE_O == 3'h5)
        else $error("retry with zero setting");
    AST_LATCH_OFF: assert property (STATE_O == 3'h5 |-> !OUTPUT_EN_O)
        else $error("output on while latched");
    AST_ATT_LIMIT: assert property (STATE_O == 3'h4 && rtry != 3'h7
        |-> ATTEMPTS_O <= rtry && ATTEMPTS_O != 3'h0)
        else $error("attempt count out of range");
    AST_FOREVER: assert property (STATE_O == 3'h4 && rtry == 3'h7 |-> ATTEMPTS_O == 3'h0)
        else $error("attempts counted in endless retry");
    AST_OFF: assert property ($fell(OPERATION_ON_I)
        |-> ##[1:2] STATE_O == 3'h0 && ATTEMPTS_O == 3'h0 && !OUTPUT_EN_O)
        else $error("off command not obeyed");
    AST_READ: assert property (REG_RD_I && REG_CMD_I == 8'h5A |=> REG_RDATA_O == $past(act_r))
        else $error("read data wrong");
    cover property (hit && resp == 2'h1);
    cover property (STATE_O == 3'h4 && rtry == 3'h6 && ATTEMPTS_O == 3'h6);
    cover property ($rose(STATE_O == 3'h5));
endmodule
bind ivf_fault_ctrl ivf_chk i_chk (.CLK_I, .RST_I, .REG_WR_I, .REG_RD_I, .REG_CMD_I,
    .REG_WDATA_I, .REG_RDATA_O, .UV_FAULT_I, .OPERATION_ON_I, .OUTPUT_EN_O, .STATE_O,
    .ATTEMPTS_O, .OTHER_FAULT_I);

// [sim/tb.sv]
// testbench for the fault response controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, rst = 1, uv = 0, ctrl = 1, op = 1, oth = 0;
    logic [15:0] unit = 16'h0002;
    wire        wr, rd, clr, sclr, en, ust;
    wire [7:0]  cmd, wdata, rdata;
    wire [2:0]  st, att;
    int         n_fail = 0, tests_run = 0, cyc = 0, len;
    logic [7:0] rv;
    always #4 clk = ~clk;
    ivf_host_model i_host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .cmd(cmd),
        .wdata(wdata), .clr(clr), .sclr(sclr));
    ivf_fault_ctrl i_dut (.CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_CMD_I(cmd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .UNIT_CYC_I(unit),
        .UV_FAULT_I(uv), .CTRL_PIN_I(ctrl), .OPERATION_ON_I(op), .CLEAR_FAULTS_I(clr),
        .STATUS_CLR_I(sclr), .OTHER_FAULT_I(oth), .OUTPUT_EN_O(en), .UV_STATUS_O(ust),
        .STATE_O(st), .ATTEMPTS_O(att));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait for a state, then compare it
    task automatic wait_st(input logic [2:0] s);
        for (int k = 0; k < 300 && st !== s; k++) step(1);
        check(8'(st), 8'(s));
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        step(10);
        rst = 0;
        wait_st(3'h1);
        i_host.rd_reg(8'h5A, rv);
        check(rv, 8'hC0);
        i_host.wr_reg(8'h5B, 8'h12);
        i_host.wr_reg(8'h5A, 8'h3C);
        i_host.rd_reg(8'h5A, rv);
        check(rv, 8'h3C);
        i_host.rd_reg(8'h5B, rv);
        check(rv, 8'h00);
        $display("test registers done");
        uv = 1;
        step(6);
        check(8'(en), 8'h01);
        check(8'(st), 8'h01);
        uv = 0;
        i_host.clear(1'b0);
        i_host.wr_reg(8'h5A, 8'hC0);
        uv = 1;
        step(3);
        check(8'(st), 8'h05);
        uv = 0;
        step(4);
        check(8'(en), 8'h00);
        i_host.clear(1'b1);
        wait_st(3'h1);
        i_host.wr_reg(8'h5A, 8'h80);
        uv = 1;
        step(3);
        check(8'(st), 8'h05);
        uv = 0;
        step(3);
        check(8'(en), 8'h00);
        i_host.clear(1'b0);
        wait_st(3'h1);
        $display("test ignore and latch done");
        for (int n = 1; n <= 6; n++) begin
            unit = 16'(n);
            i_host.wr_reg(8'h5A, {2'b10, 3'(n), 3'(n % 3)});
            uv = 1;
            wait_st(3'h3);
            for (len = 0; st === 3'h3 && len < 400; len++) step(1);
            check(8'(len >= (n << (n % 3)) && len <= (n << (n % 3)) + 2), 8'h01);
            wait_st(3'h5);
            check(8'(att), 8'(n));
            uv = 0;
            i_host.clear(1'b0);
            wait_st(3'h1);
            check(8'(att), 8'h00);
        end
        $display("test retry counts done");
        unit = 16'h0002;
        i_host.wr_reg(8'h5A, 8'h48);
        uv = 1;
        step(1);
        check(8'(st), 8'h02);
        check(8'(en), 8'h01);
        wait_st(3'h3);
        uv = 0;
        wait_st(3'h4);
        check(8'(en), 8'h01);
        wait_st(3'h1);
        $display("test delay done");
        i_host.wr_reg(8'h5A, 8'hB8);
        uv = 1;
        step(60);
        check(8'(st == 3'h5), 8'h00);
        check(8'(att), 8'h00);
        oth = 1;
        step(3);
        check(8'(st), 8'h05);
        oth = 0;
        uv = 0;
        op = 0;
        step(3);
        check(8'(st), 8'h00);
        op = 1;
        wait_st(3'h1);
        check(8'(ust), 8'h00);
        // control pin off stops endless retry, then on again restarts clean
        uv = 1;
        step(10);
        uv = 0;
        ctrl = 0;
        step(4);
        check(8'(st), 8'h00);
        check(8'(att), 8'h00);
        ctrl = 1;
        wait_st(3'h1);
        check(8'(ust), 8'h00);
        $display("test endless retry done");
        give_verdict();
    end
endmodule
